// File: shared/boot_source_select_pkg.sv
// Purpose: types of the boot source selector
// Assumes: constants come from the _regs header
// Notes: every design module keeps its state in one struct
`include "boot_source_select_regs.svh"
package boot_source_select_pkg;

  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_DECIDE = 2'b01,
    ST_RUN    = 2'b11
  } boot_state_t;

  typedef struct packed {
    boot_state_t st;
    logic        pin_s1;
    logic        pin_s2;
    logic        pol_s1;
    logic        pol_s2;
    logic        strap_s1;
    logic        strap_s2;
    logic        tool_s1;
    logic        tool_s2;
    logic        was_asserted;
    logic        strap_high;
    logic [15:0] fetch;
    logic        rom_sel;
    logic        run;
    logic        dbl;
    logic        osc_b;
    logic        expanded_ram_inhibit_bit_en;
    logic [2:0]  lock;
    logic        strap_oe;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        ready;
    logic        resp;
    logic        prog_start;
    logic [1:0]  prog_idx;
    logic [7:0]  prog_data;
  } ctrl_state_t;

  typedef struct packed {
    logic                   busy;
    logic                   done;
    logic [`PROG_CNT_W-1:0] count;
  } timer_state_t;

  typedef struct packed {
    logic [3:0][7:0] word;
    logic [7:0]      rdata;
    logic [7:0]      cfg;
  } mem_state_t;

endpackage

// File: shared/boot_source_select_regs.svh
// Purpose: constants of the boot source selector
// Assumes: 100 MHz system clock, AHB-Lite register access
`ifndef BOOT_SOURCE_SELECT_REGS_SVH
`define BOOT_SOURCE_SELECT_REGS_SVH

// register byte offsets
`define OFS_HW_SHADOW   8'h00
`define OFS_BOOT_VECTOR 8'h04
`define OFS_BOOT_STATUS 8'h08
`define OFS_SW_PROTECT  8'h0C
`define OFS_STATUS      8'h10
`define OFS_FETCH_ADDR  8'h14
`define OFS_API_ENTRY   8'h18
`define OFS_FUSE_PROG   8'h1C

// nonvolatile byte slots
`define IDX_CFG 2'h0
`define IDX_SBV 2'h1
`define IDX_BSB 2'h2
`define IDX_SSB 2'h3

// shadow byte fields
`define CFG_SPEED_BIT 7
`define CFG_JUMP_BIT  6
`define CFG_OSC_BIT   5
`define CFG_EXPANDED_RAM_INHIBIT_BIT_BIT  3
`define CFG_LOCK_MSB  2
`define CFG_SW_MASK   8'hE0
`define CFG_TOOL_MASK 8'h0F
`define SSB_KEEP_MASK 8'hFC

// defaults of the nonvolatile bytes
`define CFG_DEFAULT 8'hBB
`define SBV_DEFAULT 8'hFC
`define BSB_DEFAULT 8'hFF
`define SSB_DEFAULT 8'hFF

// start addresses
`define ADDR_LOADER    16'hF800
`define ADDR_APP       16'h0000
`define ADDR_API_ENTRY 16'hFFF0

// status register fields
`define STS_BUSY_BIT   0
`define STS_STRAP_BIT  1
`define STS_ROM_BIT    2
`define STS_RUN_BIT    3
`define STS_TOOL_BIT   4

// program timing
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS  10000000
`define PROG_CYCLES   (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define PROG_CNT_W    20

`endif

// File: src/boot_fuse_mem.sv
// Purpose: nonvolatile boot bytes (shadow, vector, status, protect)
// Assumes: one write port, one registered read port
// Notes: reset loads the documented defaults
`timescale 1ns/1ps
`include "boot_source_select_regs.svh"
module boot_fuse_mem (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       we_in,
  input  wire logic [1:0] waddr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic [1:0] raddr_in,
  output logic      [7:0] rdata_out,
  output logic      [7:0] cfg_out
);
  import boot_source_select_pkg::*;

  mem_state_t s_r;
  mem_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (we_in) begin
      s_nxt.word[waddr_in] = wdata_in;
    end
    s_nxt.rdata = s_r.word[raddr_in];
    s_nxt.cfg   = s_nxt.word[`IDX_CFG];
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_r.word[`IDX_CFG] <= `CFG_DEFAULT;
      s_r.word[`IDX_SBV] <= `SBV_DEFAULT;
      s_r.word[`IDX_BSB] <= `BSB_DEFAULT;
      s_r.word[`IDX_SSB] <= `SSB_DEFAULT;
      s_r.rdata          <= 8'h00;
      s_r.cfg            <= `CFG_DEFAULT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rdata;
  assign cfg_out   = s_r.cfg;
endmodule

// File: src/boot_program_timer.sv
// Purpose: times one nonvolatile byte program operation
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: done pulses once, CYCLES edges after start
`timescale 1ns/1ps
`include "boot_source_select_regs.svh"
module boot_program_timer #(
  parameter int unsigned CYCLES = `PROG_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  import boot_source_select_pkg::*;

  localparam logic [`PROG_CNT_W-1:0] LAST = `PROG_CNT_W'(CYCLES - 1);

  timer_state_t s_r;
  timer_state_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (s_r.busy) begin
      if (s_r.count == LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 1'b1;
      end
    end else if (start_in) begin
      s_nxt.busy  = 1'b1;
      s_nxt.count = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_out = s_r.busy;
  assign done_out = s_r.done;
endmodule

// File: src/boot_source_select.sv
// Purpose: picks the core start address at reset release, holds boot bytes
// Assumes: reset pin, polarity and strap pins are asynchronous
// Notes: registers reached over AHB-Lite, reads take one wait state
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "boot_source_select_regs.svh"
module boot_source_select #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        reset_pin_in,
  input  wire logic        reset_polarity_select_in,
  input  wire logic        boot_strap_pin_in,
  output logic             boot_strap_pin_out,
  output logic             boot_strap_pin_oe_out,
  input  wire logic        prog_tool_mode_in,
  output logic [15:0]      fetch_start_addr_out,
  output logic             boot_rom_sel_out,
  output logic             core_run_out,
  output logic             double_speed_mode_out,
  output logic             startup_osc_b_out,
  output logic             expanded_ram_enable_out,
  output logic [2:0]       memory_lock_level_out,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);
  import boot_source_select_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] slot_of(input logic [7:0] addr);
    slot_of = (addr == `OFS_FUSE_PROG) ? `IDX_CFG : addr[3:2];
  endfunction

  function automatic logic [7:0] merge_prog(input logic [1:0] idx,
                                            input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic       tool);
    logic [7:0] mask;
    mask       = tool ? (`CFG_SW_MASK | `CFG_TOOL_MASK) : `CFG_SW_MASK;
    merge_prog = wd;
    if (idx == `IDX_CFG) begin
      merge_prog = (wd & mask) | (cur & ~mask);
    end else if (idx == `IDX_SSB) begin
      merge_prog = wd | `SSB_KEEP_MASK;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage and program timer

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;
  logic        timer_busy;
  logic        timer_done;
  logic [7:0]  mem_rdata;
  logic [7:0]  cfg;
  logic [1:0]  mem_raddr;
  logic        asserted;
  logic        take;
  logic        busy;

  assign mem_raddr = slot_of(haddr_in[7:0]);

  boot_fuse_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .we_in      (timer_done),
    .waddr_in   (s_r.prog_idx),
    .wdata_in   (s_r.prog_data),
    .raddr_in   (mem_raddr),
    .rdata_out  (mem_rdata),
    .cfg_out    (cfg)
  );

  boot_program_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .start_in   (s_r.prog_start),
    .busy_out   (timer_busy),
    .done_out   (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt            = s_r;
    s_nxt.pin_s1     = reset_pin_in;
    s_nxt.pin_s2     = s_r.pin_s1;
    s_nxt.pol_s1     = reset_polarity_select_in;
    s_nxt.pol_s2     = s_r.pol_s1;
    s_nxt.strap_s1   = boot_strap_pin_in;
    s_nxt.strap_s2   = s_r.strap_s1;
    s_nxt.tool_s1    = prog_tool_mode_in;
    s_nxt.tool_s2    = s_r.tool_s1;
    s_nxt.prog_start = 1'b0;
    s_nxt.resp       = 1'b0;
    // polarity one: reset active high, released on the falling edge
    asserted           = (s_r.pin_s2 == s_r.pol_s2);
    s_nxt.was_asserted = asserted;

    case (s_r.st)
      ST_HOLD: begin
        s_nxt.run      = 1'b0;
        s_nxt.strap_oe = 1'b0;
        if (s_r.was_asserted && !asserted) begin
          s_nxt.strap_high = s_r.strap_s2;
          s_nxt.st         = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (!s_r.strap_high) begin
          s_nxt.fetch   = `ADDR_LOADER;
          s_nxt.rom_sel = 1'b1;
        end else if (!cfg[`CFG_JUMP_BIT]) begin
          s_nxt.fetch   = `ADDR_LOADER;
          s_nxt.rom_sel = 1'b1;
        end else begin
          s_nxt.fetch   = `ADDR_APP;
          s_nxt.rom_sel = 1'b0;
        end
        s_nxt.dbl     = !cfg[`CFG_SPEED_BIT];
        s_nxt.osc_b   = !cfg[`CFG_OSC_BIT];
        s_nxt.expanded_ram_inhibit_bit_en = cfg[`CFG_EXPANDED_RAM_INHIBIT_BIT_BIT];
        s_nxt.lock    = cfg[`CFG_LOCK_MSB:0];
        s_nxt.st      = ST_RUN;
      end
      ST_RUN: begin
        s_nxt.run      = 1'b1;
        s_nxt.strap_oe = 1'b1;
      end
      default: begin
        s_nxt.st = ST_HOLD;
      end
    endcase

    if (asserted) begin
      s_nxt.st       = ST_HOLD;
      s_nxt.run      = 1'b0;
      s_nxt.strap_oe = 1'b0;
    end

    // bus data phase of a read
    if (s_r.rd_pend) begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.ready   = 1'b1;
      case (s_r.addr)
        `OFS_HW_SHADOW:   s_nxt.rdata = {24'h00_0000, cfg};
        `OFS_BOOT_VECTOR: s_nxt.rdata = {24'h00_0000, mem_rdata};
        `OFS_BOOT_STATUS: s_nxt.rdata = {24'h00_0000, mem_rdata};
        `OFS_SW_PROTECT:  s_nxt.rdata = {24'h00_0000, mem_rdata};
        `OFS_STATUS: begin
          s_nxt.rdata                 = 32'h0000_0000;
          s_nxt.rdata[`STS_BUSY_BIT]  = timer_busy | s_r.prog_start;
          s_nxt.rdata[`STS_STRAP_BIT] = !s_r.strap_high;
          s_nxt.rdata[`STS_ROM_BIT]   = s_r.rom_sel;
          s_nxt.rdata[`STS_RUN_BIT]   = s_r.run;
          s_nxt.rdata[`STS_TOOL_BIT]  = s_r.tool_s2;
        end
        `OFS_FETCH_ADDR:  s_nxt.rdata = {16'h0000, s_r.fetch};
        `OFS_API_ENTRY:   s_nxt.rdata = {16'h0000, `ADDR_API_ENTRY};
        default:          s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // bus data phase of a write: vector, status, protect or fuse write starts one program operation if idle
    busy = timer_busy | s_r.prog_start;
    if (s_r.wr_pend) begin
      s_nxt.wr_pend = 1'b0;
      if (!busy) begin
        case (s_r.addr)
          `OFS_BOOT_VECTOR, `OFS_BOOT_STATUS, `OFS_SW_PROTECT, `OFS_FUSE_PROG: begin
            s_nxt.prog_start = 1'b1;
            s_nxt.prog_idx   = slot_of(s_r.addr);
            s_nxt.prog_data  = merge_prog(slot_of(s_r.addr), cfg, hwdata_in[7:0], s_r.tool_s2);
          end
          default: begin
            s_nxt.prog_start = 1'b0;
          end
        endcase
      end
    end

    // bus address phase
    take = hsel_in && htrans_in[1] && hready_in;
    if (take) begin
      s_nxt.addr    = haddr_in[7:0];
      s_nxt.rd_pend = !hwrite_in;
      s_nxt.wr_pend = hwrite_in;
      s_nxt.ready   = hwrite_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_r              <= '0;
      s_r.was_asserted <= 1'b1;
      s_r.strap_high   <= 1'b1;
      s_r.ready        <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign boot_strap_pin_out      = s_r.strap_oe;
  assign boot_strap_pin_oe_out   = s_r.strap_oe;
  assign fetch_start_addr_out    = s_r.fetch;
  assign boot_rom_sel_out        = s_r.rom_sel;
  assign core_run_out            = s_r.run;
  assign double_speed_mode_out   = s_r.dbl;
  assign startup_osc_b_out       = s_r.osc_b;
  assign expanded_ram_enable_out = s_r.expanded_ram_inhibit_bit_en;
  assign memory_lock_level_out   = s_r.lock;
  assign hrdata_out              = s_r.rdata;
  assign hreadyout_out           = s_r.ready;
  assign hresp_out               = s_r.resp;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_strap_forces_rom: assert property (
    s_r.st == ST_DECIDE && !s_r.strap_high |=> fetch_start_addr_out == `ADDR_LOADER && boot_rom_sel_out
  ) else $error("strap low did not select the loader");

  a_strap_over_fuse: assert property (
    s_r.st == ST_DECIDE && !s_r.strap_high && cfg[`CFG_JUMP_BIT] |=> boot_rom_sel_out ##1 core_run_out
  ) else $error("fuse overrode the strap");

  a_fuse_selects_app: assert property (
    s_r.st == ST_DECIDE && s_r.strap_high && cfg[`CFG_JUMP_BIT]
    |=> fetch_start_addr_out == `ADDR_APP && !boot_rom_sel_out
  ) else $error("unprogrammed fuse did not start the application");

  a_fuse_selects_ldr: assert property (
    s_r.st == ST_DECIDE && s_r.strap_high && !cfg[`CFG_JUMP_BIT] |=> fetch_start_addr_out == `ADDR_LOADER
  ) else $error("programmed fuse did not start the loader");

  a_run_after_choice: assert property (
    $rose(core_run_out) |-> $past(s_r.st, 2) == ST_DECIDE
  ) else $error("core released before the boot choice");

  a_choice_stays_put: assert property (
    core_run_out && $past(core_run_out) |-> $stable(fetch_start_addr_out) && $stable(boot_rom_sel_out)
  ) else $error("boot choice changed after the reset edge");

  a_speed_follows: assert property (
    s_r.st == ST_DECIDE |=> double_speed_mode_out == !$past(cfg[`CFG_SPEED_BIT])
    && startup_osc_b_out == !$past(cfg[`CFG_OSC_BIT])
  ) else $error("speed or oscillator does not follow the shadow");

  a_lock_protected: assert property (
    timer_done && s_r.prog_idx == `IDX_CFG && !$past(s_r.tool_s2, PROG_CYCLES > 1 ? 2 : 1)
    |=> cfg[3:0] == $past(cfg[3:0])
  ) else $error("lock or expanded RAM bit changed without programmer");

  a_api_entry_read: assert property (
    take && !hwrite_in && haddr_in[7:0] == `OFS_API_ENTRY
    |=> !hreadyout_out ##1 hreadyout_out && hrdata_out == {16'h0000, `ADDR_API_ENTRY}
  ) else $error("entry point register read wrong");

  a_shadow_read: assert property (
    take && !hwrite_in && haddr_in[7:0] == `OFS_HW_SHADOW && !timer_busy
    |=> ##1 hrdata_out == {24'h00_0000, cfg}
  ) else $error("shadow read does not mirror the fuses");

  a_strap_held_once: assert property (
    s_r.st != ST_HOLD && $past(s_r.st) != ST_HOLD |-> $stable(s_r.strap_high)
  ) else $error("strap choice changed after the reset edge");

  a_busy_write_drop: assert property (
    s_r.wr_pend && busy |=> !s_r.prog_start
  ) else $error("write accepted while a program operation ran");

  a_pin_stops_core: assert property (
    asserted |=> !core_run_out
  ) else $error("core kept running with reset asserted");

  a_ram_lock_follow: assert property (
    s_r.st == ST_DECIDE |=> expanded_ram_enable_out == $past(cfg[`CFG_EXPANDED_RAM_INHIBIT_BIT_BIT])
    && memory_lock_level_out == $past(cfg[`CFG_LOCK_MSB:0])
  ) else $error("expanded RAM or lock level does not follow the shadow");

  c_strap_boot: cover property (s_r.st == ST_DECIDE && !s_r.strap_high);
  c_busy_write: cover property (s_r.wr_pend && busy);
  c_app_boot:   cover property ($rose(core_run_out) && !boot_rom_sel_out);
  c_prog_done:  cover property (timer_done);
endmodule

// File: testbench/boot_reset_strap_model.sv
// Purpose: reset pin and boot strap circuit outside the boot selector
// Assumes: the strap line has a pull-up while nobody drives it
// Notes: boot() asserts reset, releases it, then releases the strap
`timescale 1ns/1ps
module boot_reset_strap_model (
  input  wire logic clk_in,
  input  wire logic strap_drv_in,
  input  wire logic strap_oe_in,
  output logic      reset_pin_out,
  output logic      polarity_out,
  output logic      strap_level_out
);
  logic m_en;
  logic m_val;

  // the device wins while it drives; otherwise our level or the pull-up
  assign strap_level_out = strap_oe_in ? strap_drv_in : (m_en ? m_val : 1'b1);

  // strap left to the pull-up at power-on
  initial begin
    polarity_out = 1'b1;
    reset_pin_out = 1'b0;
    m_en = 1'b0;
    m_val = 1'b1;
  end

  task automatic boot(input logic reset_polarity_select, input logic strap, input logic late);
    @(posedge clk_in);
    polarity_out <= reset_polarity_select;
    reset_pin_out <= reset_polarity_select;
    m_en <= 1'b1;
    m_val <= strap;
    repeat (8) @(posedge clk_in);
    reset_pin_out <= ~reset_polarity_select;
    repeat (2) @(posedge clk_in);
    m_val <= late;
    repeat (2) @(posedge clk_in);
    // strap let go before the device starts driving it
    m_en <= 1'b0;
  endtask
endmodule

// File: testbench/boot_source_select_test.sv
// Purpose: self-checking bench of the boot source selector
// Assumes: program time shortened to 8 cycles
// Notes: registers reached through an AHB-Lite master task
`timescale 1ns/1ps
`include "boot_source_select_regs.svh"
module boot_source_select_test;
  logic        clk_sys_in;
  logic        reset_in;
  logic        tool;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        strap_out;
  logic        strap_oe;
  logic        run;
  logic        rom;
  logic        dbl;
  logic        oscb;
  logic        expanded_ram_inhibit_bit;
  logic [15:0] fetch;
  logic [2:0]  lock;
  logic        pin;
  logic        reset_polarity_select;
  logic        strap_lvl;
  int          n_fail;
  int          compares;

  boot_source_select #(.PROG_CYCLES(8)) i_dut (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reset_pin_in(pin),
    .reset_polarity_select_in(reset_polarity_select), .boot_strap_pin_in(strap_lvl),
    .boot_strap_pin_out(strap_out), .boot_strap_pin_oe_out(strap_oe),
    .prog_tool_mode_in(tool), .fetch_start_addr_out(fetch), .boot_rom_sel_out(rom),
    .core_run_out(run), .double_speed_mode_out(dbl), .startup_osc_b_out(oscb),
    .expanded_ram_enable_out(expanded_ram_inhibit_bit), .memory_lock_level_out(lock), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp));

  boot_reset_strap_model i_far (
    .clk_in(clk_sys_in), .strap_drv_in(strap_out), .strap_oe_in(strap_oe),
    .reset_pin_out(pin), .polarity_out(reset_polarity_select), .strap_level_out(strap_lvl));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin @(posedge clk_sys_in); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk_sys_in); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin n_fail++; conclude(); end
    chk(hresp, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  // program write; extra tries a second write while busy
  task automatic wprog(input logic [7:0] a, input logic [31:0] d, input logic extra);
    logic [31:0] s;
    int n;
    wr(a, d);
    rd(`OFS_STATUS, s);
    chk(s & 32'h0000_0001, 32'h0000_0001);
    if (extra) wr(`OFS_BOOT_STATUS, 32'h0000_0000);
    n = 0;
    do begin rd(`OFS_STATUS, s); n++; end while (s[0] !== 1'b0 && n < 10);
    if (n >= 10) begin n_fail++; conclude(); end
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (run !== 1'b1 && n < 40) begin @(posedge clk_sys_in); n++; end
    if (n >= 40) begin n_fail++; conclude(); end
  endtask

  task automatic reboot(input logic p, input logic s, input logic late);
    fork
      i_far.boot(p, s, late);
      begin repeat (8) @(posedge clk_sys_in); chk(run, 0); end
    join
    wait_run();
  endtask

  task automatic chk_boot(input logic [15:0] f, input logic r, d, o, x, input logic [2:0] l);
    chk({fetch, rom, dbl, oscb, expanded_ram_inhibit_bit, lock, strap_oe, strap_out}, {f, r, d, o, x, l, 2'b11});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic power_up;
    logic [31:0] d;
    wait_run();
    chk_boot(16'hF800, 1, 0, 0, 1, 3'h3);
    rd(`OFS_HW_SHADOW, d);
    chk(d, 32'h0000_00BB);
    rd(`OFS_API_ENTRY, d);
    chk(d, 32'h0000_FFF0);
    rd(8'h20, d);
    chk(d, 32'h0000_0000);
    wr(`OFS_HW_SHADOW, 32'h0000_0000);
    rd(`OFS_HW_SHADOW, d);
    chk(d, 32'h0000_00BB);
  endtask

  task automatic sw_bytes;
    logic [31:0] d;
    rd(`OFS_BOOT_VECTOR, d);
    chk(d, 32'h0000_00FC);
    wprog(`OFS_BOOT_VECTOR, 32'h0000_0040, 1'b1);
    rd(`OFS_BOOT_VECTOR, d);
    chk(d, 32'h0000_0040);
    rd(`OFS_BOOT_STATUS, d);
    chk(d, 32'h0000_00FF);
    wprog(`OFS_BOOT_STATUS, 32'h0000_0000, 1'b0);
    rd(`OFS_BOOT_STATUS, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic fuse_app;
    logic [31:0] d;
    wprog(`OFS_FUSE_PROG, 32'h0000_0040, 1'b0);
    rd(`OFS_HW_SHADOW, d);
    chk(d, 32'h0000_005B);
    reboot(1'b1, 1'b1, 1'b1);
    chk_boot(16'h0000, 0, 1, 1, 1, 3'h3);
    rd(`OFS_FETCH_ADDR, d);
    chk(d, 32'h0000_0000);
    rd(`OFS_STATUS, d);
    chk(d, 32'h0000_0008);
  endtask

  task automatic tool_strap;
    logic [31:0] d;
    tool <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(`OFS_STATUS, d);
    chk(d, 32'h0000_0018);
    wprog(`OFS_FUSE_PROG, 32'h0000_0047, 1'b0);
    tool <= 1'b0;
    rd(`OFS_HW_SHADOW, d);
    chk(d, 32'h0000_0057);
    reboot(1'b1, 1'b0, 1'b1);
    chk_boot(16'hF800, 1, 1, 1, 0, 3'h7);
    rd(`OFS_STATUS, d);
    chk(d, 32'h0000_000E);
  endtask

  task automatic low_pol;
    reboot(1'b0, 1'b1, 1'b0);
    chk_boot(16'h0000, 0, 1, 1, 0, 3'h7);
  endtask

  initial begin
    reset_in = 1'b1;
    tool = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    n_fail = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    power_up();
    sw_bytes();
    fuse_app();
    tool_strap();
    low_pol();
    conclude();
  end
endmodule
